// ==== core/qd_consts.svh ====
// timing counts and field positions for the quad-lane dram controller
// How it works
// - after power-up wait 100 us, then eight refresh cycles before any access.
// - repeat the eight-cycle wake-up whenever the refresh interval was exceeded.
// - refresh all 512 rows within every 16 ms, in any order.
// - a read ends by meeting either the column or row referenced read hold.
// - write strobe low no later than first column strobe fall is an early write.
// - write strobe late after row 100, address 65, strobe 50 ns is read-write.
// - hidden refresh after a write keeps write strobe low, output enable high.
// - at least one lane strobe goes low; unused lanes stay high and untouched.
// - every lane strobe that goes low meets all timing or its data is lost.
// - output enable stays high 20 ns after write strobe in late-write cycles.
// - twenty address bits go ten at a time: row at row fall, column at cas.
// - write strobe high reads, low writes; data latched at the later fall.
`ifndef QD_CONSTS_SVH
`define QD_CONSTS_SVH

`define QD_CLK_NS        50
`define QD_CEIL_CYC(ns)  (((ns) + `QD_CLK_NS - 1) / `QD_CLK_NS)

`define QD_POWERUP_US    100
`define QD_POWERUP_CYC   `QD_CEIL_CYC(`QD_POWERUP_US * 1000)
`define QD_REF_PERIOD_MS 16
`define QD_REF_ROWS      512
`define QD_ROW_INT_CYC   ((`QD_REF_PERIOD_MS * 1000000) / (`QD_REF_ROWS * `QD_CLK_NS))
`define QD_WAKE_CYCLES   8
`define QD_OWED_LIMIT    512

`define QD_RWD_NS        100
`define QD_AWD_NS        65
`define QD_CWD_NS        50
`define QD_OEH_NS        20
`define QD_OD_NS         20
`define QD_RP_NS         50
`define QD_RAS_MIN_NS    70
`define QD_RWD_CYC       `QD_CEIL_CYC(`QD_RWD_NS)
`define QD_AWD_CYC       `QD_CEIL_CYC(`QD_AWD_NS)
`define QD_CWD_CYC       `QD_CEIL_CYC(`QD_CWD_NS)
`define QD_OEH_CYC       `QD_CEIL_CYC(`QD_OEH_NS)
`define QD_OD_CYC        `QD_CEIL_CYC(`QD_OD_NS)
`define QD_RP_CYC        `QD_CEIL_CYC(`QD_RP_NS)
`define QD_RAS_MIN_CYC   `QD_CEIL_CYC(`QD_RAS_MIN_NS)

`define QD_ROW_MSB       19
`define QD_ROW_LSB       10
`define QD_COL_MSB       9
`define QD_COL_LSB       0
`define QD_LANES_IDLE    4'hF

`endif

// ==== core/qd_pkg.sv ====
// types shared by the quad-lane dram controller
package qd_pkg;

    typedef logic [19:0] qd_addr_t;
    typedef logic [9:0]  qd_half_t;
    typedef logic [3:0]  qd_lanes_t;

    typedef enum logic [3:0] {
        ST_POWER,
        ST_IDLE,
        ST_ROW,
        ST_COL,
        ST_DATA,
        ST_WHOLD,
        ST_LATE_OE,
        ST_LATE_WE,
        ST_REF_CAS,
        ST_REF_RAS,
        ST_END
    } qd_state_t;

endpackage : qd_pkg

// ==== core/qd_refresh_timer.sv ====
// power-up pause and per-row refresh interval timer
`timescale 1ns/1ns
`include "qd_consts.svh"
module qd_refresh_timer (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    output logic      pwr_done,
    output logic      row_tick
);
    import qd_pkg::*;

    localparam logic [10:0] PWR_LAST = 11'(`QD_POWERUP_CYC - 1);
    localparam logic [9:0]  ROW_LAST = 10'(`QD_ROW_INT_CYC - 1);

    logic [10:0] pwr_cnt_ff;
    logic [9:0]  row_cnt_ff;
    logic        pwr_done_ff;
    logic        row_tick_ff;

    wire row_wrap = pwr_done_ff && (row_cnt_ff == ROW_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_cnt_ff  <= 11'h000;
            row_cnt_ff  <= 10'h000;
            pwr_done_ff <= 1'b0;
            row_tick_ff <= 1'b0;
        end else if (ce) begin
            if (!pwr_done_ff) begin
                pwr_cnt_ff  <= pwr_cnt_ff + 11'h001;
                pwr_done_ff <= (pwr_cnt_ff == PWR_LAST);
            end
            // interval floors the 16 ms budget, so the row rate never lags
            if (pwr_done_ff) begin
                row_cnt_ff <= row_wrap ? 10'h000 : row_cnt_ff + 10'h001;
            end
            row_tick_ff <= row_wrap;
        end
    end

    assign pwr_done = pwr_done_ff;
    assign row_tick = row_tick_ff;

endmodule : qd_refresh_timer

// ==== core/qd_ctrl.sv ====
// host-side access and refresh controller for a quad-lane dram
`timescale 1ns/1ns
`include "qd_consts.svh"
module qd_ctrl (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic          req_valid,
    output logic               req_ready,
    input  wire logic          req_write,
    input  wire logic          req_rmw,
    input  wire qd_pkg::qd_addr_t  req_addr,
    input  wire qd_pkg::qd_lanes_t req_lanes,
    input  wire qd_pkg::qd_lanes_t req_wdata,
    output logic               resp_valid,
    output qd_pkg::qd_lanes_t  resp_rdata,
    output logic               init_done,
    output logic               row_strobe_n,
    output qd_pkg::qd_lanes_t  lane_column_strobes_n,
    output logic               write_strobe_n,
    output logic               output_enable_n,
    output qd_pkg::qd_half_t   mem_addr,
    input  wire qd_pkg::qd_lanes_t lane_data_pin_i,
    output qd_pkg::qd_lanes_t  lane_data_pin_o,
    output qd_pkg::qd_lanes_t  lane_data_pin_oe
);
    import qd_pkg::*;

    localparam logic [9:0] OWED_LIMIT = 10'(`QD_OWED_LIMIT);
    localparam logic [3:0] WAKE_N     = 4'(`QD_WAKE_CYCLES);
    localparam logic [3:0] RWD_CYC    = 4'(`QD_RWD_CYC);
    localparam logic [3:0] AWD_CYC    = 4'(`QD_AWD_CYC);
    localparam logic [3:0] CWD_CYC    = 4'(`QD_CWD_CYC);

    // extra cycles a state holds beyond its first
    function automatic logic [2:0] qd_hold(input qd_state_t s);
        case (s)
            ST_REF_RAS: qd_hold = 3'(`QD_RAS_MIN_CYC - 1);
            ST_END:     qd_hold = 3'(`QD_RP_CYC - 1);
            ST_LATE_OE: qd_hold = 3'(`QD_OD_CYC - 1);
            ST_LATE_WE: qd_hold = 3'(`QD_OEH_CYC - 1);
            default:    qd_hold = 3'h0;
        endcase
    endfunction : qd_hold

    ////////////////////////////////////////////////////////////////////////
    // state
    qd_state_t  state_ff;
    qd_state_t  nxt_state;
    logic [2:0] wt_ff;
    qd_addr_t   addr_ff;
    qd_lanes_t  lane_ff;
    qd_lanes_t  wdata_ff;
    qd_lanes_t  rdata_ff;
    logic       wr_ff;
    logic       rmw_ff;
    logic       resp_ff;
    logic       init_ff;
    logic [3:0] wake_ff;
    logic [9:0] owed_ff;
    logic [9:0] nxt_owed;
    logic [3:0] nxt_wake;
    logic       ras_n_ff;
    qd_lanes_t  cas_n_ff;
    logic       we_n_ff;
    logic       oe_n_ff;
    qd_half_t   maddr_ff;
    qd_lanes_t  dq_o_ff;
    qd_lanes_t  dq_oe_ff;
    logic       pwr_done;
    logic       row_tick;

    qd_refresh_timer u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pwr_done (pwr_done),
        .row_tick (row_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire advance   = (wt_ff == 3'h0);
    wire early     = wr_ff && !rmw_ff;
    wire plain_rd  = !wr_ff && !rmw_ff;
    wire st_idle   = (state_ff == ST_IDLE);
    wire st_row    = (state_ff == ST_ROW);
    wire st_col    = (state_ff == ST_COL);
    wire st_data   = (state_ff == ST_DATA);
    wire st_whold  = (state_ff == ST_WHOLD);
    wire st_lateoe = (state_ff == ST_LATE_OE);
    wire st_latewe = (state_ff == ST_LATE_WE);
    wire st_refcas = (state_ff == ST_REF_CAS);
    wire st_refras = (state_ff == ST_REF_RAS);
    wire in_col    = st_col || st_data || st_whold || st_lateoe || st_latewe;
    wire ref_due   = (wake_ff != 4'h0) || (owed_ff != 10'h000);
    wire ref_done  = st_refras && advance;
    wire acc_end   = advance && (st_whold || st_latewe || (st_data && !rmw_ff));
    // a request with no lane enabled is no column cycle at all
    wire lanes_any = (req_lanes != 4'h0);
    wire take      = req_valid && req_ready;

    assign req_ready = st_idle && init_ff && !ref_due && lanes_any;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_POWER:   if (pwr_done) nxt_state = ST_IDLE;
            // refresh only ever starts from idle; hidden refresh is unused
            ST_IDLE:    if (ref_due) nxt_state = ST_REF_CAS;
                        else if (take) nxt_state = ST_ROW;
            ST_ROW:     nxt_state = ST_COL;
            ST_COL:     nxt_state = early ? ST_WHOLD : ST_DATA;
            ST_DATA:    nxt_state = rmw_ff ? ST_LATE_OE : ST_END;
            ST_WHOLD:   nxt_state = ST_END;
            ST_LATE_OE: if (advance) nxt_state = ST_LATE_WE;
            ST_LATE_WE: if (advance) nxt_state = ST_END;
            ST_REF_CAS: nxt_state = ST_REF_RAS;
            ST_REF_RAS: if (advance) nxt_state = ST_END;
            ST_END:     if (advance) nxt_state = ST_IDLE;
            default:    nxt_state = ST_IDLE;
        endcase
    end

    // owed rows only accumulate if refresh falls behind; at the limit the
    // 16 ms budget is already broken, so the wake-up is run again
    always_comb begin
        nxt_owed = owed_ff;
        nxt_wake = wake_ff;
        if (owed_ff == OWED_LIMIT) begin
            nxt_owed = 10'h000;
            nxt_wake = WAKE_N;
        end else begin
            if (ref_done && wake_ff != 4'h0) begin
                nxt_wake = wake_ff - 4'h1;
            end
            if (row_tick && !(ref_done && wake_ff == 4'h0)) begin
                nxt_owed = owed_ff + 10'h001;
            end else if (!row_tick && ref_done && wake_ff == 4'h0) begin
                nxt_owed = owed_ff - 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin decode; pins lag the state by one cycle
    wire       nxt_ras_n = !(st_row || in_col || st_refras);
    wire [3:0] nxt_cas_n = in_col ? ~lane_ff :
                           (st_refcas || st_refras) ? 4'h0 : `QD_LANES_IDLE;
    wire       nxt_we_n  = !(((st_col || st_whold) && early) || st_latewe);
    // output enable rises before the late write strobe and stays up after
    wire       nxt_oe_n  = !((st_col || st_data) && !early);
    wire [9:0] nxt_maddr = st_row ? addr_ff[`QD_ROW_MSB:`QD_ROW_LSB] :
                           addr_ff[`QD_COL_MSB:`QD_COL_LSB];
    wire       drive     = ((st_col || st_whold) && early) || st_latewe;
    wire [3:0] nxt_dq_oe = {4{drive}} & lane_ff;

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ST_POWER;
            wt_ff    <= 3'h0;
            wake_ff  <= WAKE_N;
            owed_ff  <= 10'h000;
            init_ff  <= 1'b0;
            resp_ff  <= 1'b0;
            ras_n_ff <= 1'b1;
            cas_n_ff <= `QD_LANES_IDLE;
            we_n_ff  <= 1'b1;
            oe_n_ff  <= 1'b1;
            dq_oe_ff <= 4'h0;
        end else if (ce) begin
            state_ff <= nxt_state;
            wt_ff    <= (nxt_state != state_ff) ? qd_hold(nxt_state) :
                        (advance ? 3'h0 : wt_ff - 3'h1);
            wake_ff  <= nxt_wake;
            owed_ff  <= nxt_owed;
            init_ff  <= pwr_done && (nxt_wake == 4'h0);
            resp_ff  <= acc_end;
            ras_n_ff <= nxt_ras_n;
            cas_n_ff <= nxt_cas_n;
            we_n_ff  <= nxt_we_n;
            oe_n_ff  <= nxt_oe_n;
            dq_oe_ff <= nxt_dq_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_ff  <= 20'h0_0000;
            lane_ff  <= 4'h0;
            wdata_ff <= 4'h0;
            wr_ff    <= 1'b0;
            rmw_ff   <= 1'b0;
            rdata_ff <= 4'h0;
            maddr_ff <= 10'h000;
            dq_o_ff  <= 4'h0;
        end else if (ce) begin
            if (take) begin
                addr_ff  <= req_addr;
                lane_ff  <= req_lanes;
                wdata_ff <= req_wdata;
                wr_ff    <= req_write;
                rmw_ff   <= req_rmw;
            end
            // sampled only in read or read-write cycles, never in the
            // undefined window between early and late write strobes
            if (st_data) begin
                rdata_ff <= lane_data_pin_i & lane_ff;
            end
            maddr_ff <= nxt_maddr;
            dq_o_ff  <= wdata_ff;
        end
    end

    assign resp_valid            = resp_ff;
    assign resp_rdata            = rdata_ff;
    assign init_done             = init_ff;
    assign row_strobe_n          = ras_n_ff;
    assign lane_column_strobes_n = cas_n_ff;
    assign write_strobe_n        = we_n_ff;
    assign output_enable_n       = oe_n_ff;
    assign mem_addr              = maddr_ff;
    assign lane_data_pin_o       = dq_o_ff;
    assign lane_data_pin_oe      = dq_oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [3:0] ras_low_cnt_ff;
    logic [3:0] cas_low_cnt_ff;
    logic [3:0] ref_seen_ff;
    logic       we_n_prev_ff;
    qd_lanes_t  cas_n_prev_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ras_low_cnt_ff <= 4'h0;
            cas_low_cnt_ff <= 4'h0;
            ref_seen_ff    <= 4'h0;
            we_n_prev_ff   <= 1'b1;
            cas_n_prev_ff  <= `QD_LANES_IDLE;
        end else if (ce) begin
            we_n_prev_ff   <= we_n_ff;
            cas_n_prev_ff  <= cas_n_ff;
            ras_low_cnt_ff <= ras_n_ff ? 4'h0 :
                (ras_low_cnt_ff == 4'hF ? 4'hF : ras_low_cnt_ff + 4'h1);
            cas_low_cnt_ff <= (cas_n_ff == `QD_LANES_IDLE) ? 4'h0 :
                (cas_low_cnt_ff == 4'hF ? 4'hF : cas_low_cnt_ff + 4'h1);
            if (ref_done && ref_seen_ff != 4'hF) begin
                ref_seen_ff <= ref_seen_ff + 4'h1;
            end
        end
    end

    wire late_we_fall = !we_n_ff && we_n_prev_ff &&
                        (cas_n_ff != `QD_LANES_IDLE) &&
                        (cas_n_prev_ff != `QD_LANES_IDLE);
    wire first_cas    = (cas_n_ff != `QD_LANES_IDLE) &&
                        (cas_n_prev_ff == `QD_LANES_IDLE) && !ras_n_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    chk_power_quiet: assert property (!pwr_done |-> ras_n_ff)
        else $error("row strobe active during power-up pause");
    chk_wake_first: assert property ($rose(init_ff) |-> ref_seen_ff >= WAKE_N)
        else $error("ready before eight wake-up refreshes");
    chk_rewake_load: assert property ((owed_ff == OWED_LIMIT) |=> wake_ff == WAKE_N)
        else $error("overdue refresh did not restart wake-up");
    chk_owed_bound: assert property (owed_ff <= OWED_LIMIT)
        else $error("owed refresh count beyond limit");
    chk_early_drive: assert property ((first_cas && !we_n_ff) |-> dq_oe_ff != 4'h0)
        else $error("early write without data driven");
    chk_late_delay: assert property (late_we_fall |->
            ras_low_cnt_ff >= RWD_CYC && cas_low_cnt_ff >= AWD_CYC &&
            cas_low_cnt_ff >= CWD_CYC)
        else $error("late write strobe too early");
    chk_oe_hold: assert property (late_we_fall |-> oe_n_ff ##1 oe_n_ff)
        else $error("output enable not held high after write strobe");
    chk_read_hold: assert property ((st_data && plain_rd) |-> we_n_ff [*3])
        else $error("write strobe dropped before read end");
    chk_lane_any: assert property (st_data |-> cas_n_ff != `QD_LANES_IDLE)
        else $error("column cycle with no lane strobe");
    chk_row_addr: assert property (($fell(ras_n_ff) &&
            cas_n_ff == `QD_LANES_IDLE) |->
            maddr_ff == addr_ff[`QD_ROW_MSB:`QD_ROW_LSB])
        else $error("row address not on pins at row strobe");
    chk_write_data: assert property ((dq_oe_ff != 4'h0) |->
            !we_n_ff && dq_o_ff == wdata_ff)
        else $error("data driven outside write strobe");

    cov_read:    cover property (st_data && plain_rd ##1 resp_ff);
    cov_early:   cover property (st_whold ##1 resp_ff);
    cov_rmw:     cover property (late_we_fall);
    cov_refresh: cover property (ref_done && wake_ff == 4'h0);

endmodule : qd_ctrl

// ==== tb/qd_mem_model.sv ====
// behavioural model of the quad-lane dram device
`timescale 1ns/1ns
module qd_mem_model (
    input  wire logic       row_strobe_n,
    input  wire logic [3:0] lane_column_strobes_n,
    input  wire logic       write_strobe_n,
    input  wire logic       output_enable_n,
    input  wire logic [9:0] mem_addr,
    input  wire logic [3:0] data_in,
    output logic      [3:0] data_out,
    output logic      [3:0] data_oe,
    output int              ref_count,
    output int              early_access
);
    logic [3:0]  cells [int];
    logic [9:0]  row    = 10'h000;
    logic [19:0] adr    = 20'h0_0000;
    logic [3:0]  q      = 4'h0;
    logic        rd_ok  = 1'b0;
    logic        is_ref = 1'b0;
    time         cas_t  = 0;
    wire         cas_any_n = &lane_column_strobes_n;

    initial begin
        ref_count = 0;
        early_access = 0;
    end

    ////////////////////////////////////////////////////////////
    task automatic store;
        logic [3:0] v;
        v = cells.exists(adr) ? cells[adr] : 4'h0;
        for (int n = 0; n < 4; n++)
            if (!lane_column_strobes_n[n])
                v[n] = data_in[n];
        cells[adr] = v;
    endtask : store

    // the address pins change on the very edge that drops the row strobe
    always @(negedge row_strobe_n) begin
        #1;
        is_ref = !cas_any_n;
        if (is_ref)
            ref_count++;
        else begin
            row = mem_addr;
            if (ref_count < 8)
                early_access++;
        end
    end

    // pins settle 1 ns after the strobe so a same-edge write strobe counts
    always @(negedge cas_any_n) begin
        cas_t = $time;
        #1;
        if (!row_strobe_n && !is_ref) begin
            adr = {row, mem_addr};
            rd_ok = write_strobe_n;
            if (!write_strobe_n)
                store();
            else if (cells.exists(adr))
                q = cells[adr];
        end
    end

    always @(negedge write_strobe_n) begin
        #1;
        if (!row_strobe_n && !cas_any_n && $time > cas_t + 1)
            store();
    end

    always @(posedge cas_any_n)
        rd_ok = 1'b0;

    // released lanes show the inverse rather than a held value
    assign data_oe = {4{rd_ok & !output_enable_n}}
                   & ~lane_column_strobes_n;
    assign data_out = q ^ ~data_oe;
endmodule : qd_mem_model

// ==== tb/qd_ctrl_test.sv ====
// self-checking bench for the quad-lane dram controller
`timescale 1ns/1ns
module qd_ctrl_test;
    import qd_pkg::*;
    logic      clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic      req_valid = 1'b0, req_write = 1'b0, req_rmw = 1'b0;
    qd_addr_t  req_addr = 20'h0_0000;
    qd_lanes_t req_lanes = 4'hF, req_wdata = 4'h0;
    logic      req_ready, resp_valid, init_done, ras_n, we_n, oe_n;
    qd_lanes_t resp_rdata, cas_n, d_i, d_o, d_oe, m_o, m_oe;
    qd_half_t  addr;
    int        bad_count = 0, n_tests = 0, clash = 0, m_ref, m_early;

    always #25 clk = ~clk;
    assign d_i = (d_oe & d_o) | (~d_oe & m_o);
    always @(posedge clk)
        if (|(d_oe & m_oe))
            clash++;

    qd_ctrl DUT (
        .clk(clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_rmw(req_rmw),
        .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .init_done(init_done), .row_strobe_n(ras_n),
        .lane_column_strobes_n(cas_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .mem_addr(addr), .lane_data_pin_i(d_i),
        .lane_data_pin_o(d_o), .lane_data_pin_oe(d_oe));

    qd_mem_model mem (
        .row_strobe_n(ras_n), .lane_column_strobes_n(cas_n),
        .write_strobe_n(we_n), .output_enable_n(oe_n), .mem_addr(addr),
        .data_in(d_o), .data_out(m_o), .data_oe(m_oe),
        .ref_count(m_ref), .early_access(m_early));

    ////////////////////////////////////////////////////////////
    task automatic check_bit(logic got, logic exp, string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s: %b vs %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic check_nib(qd_lanes_t got, qd_lanes_t exp, string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s: %h vs %h", $time, what, got, exp);
        end
    endtask : check_nib

    task automatic check_int(int got, int exp, string what);
        n_tests++;
        if (got != exp) begin
            bad_count++;
            $display("MISMATCH %0t %s: %0d vs %0d", $time, what, got, exp);
        end
    endtask : check_int

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////
    // request held until ready is seen at an edge, then dropped
    task automatic access(logic wr, logic rmw, qd_addr_t a, qd_lanes_t ln,
                          qd_lanes_t wd, output qd_lanes_t rd);
        int   k;
        logic ok;
        k = 0;
        req_write = wr;
        req_rmw = rmw;
        req_addr = a;
        req_lanes = ln;
        req_wdata = wd;
        req_valid = 1'b1;
        // ready read mid-cycle, where it has settled for the coming edge
        do begin
            @(negedge clk);
            ok = req_ready;
            @(posedge clk);
            k++;
        end while (!ok && k < 4000);
        #1;
        req_valid = 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (!resp_valid && k < 30);
        check_bit(resp_valid, 1'b1, "response");
        rd = resp_rdata;
    endtask : access

    task automatic t_reset;
        check_bit(ras_n, 1'b1, "row strobe idle");
        check_nib(cas_n, 4'hF, "column strobes idle");
        check_nib(d_oe, 4'h0, "data drive idle");
        check_bit(req_ready, 1'b0, "ready in reset");
    endtask : t_reset

    task automatic t_wakeup;
        int k;
        k = 0;
        while (init_done !== 1'b1 && k < 3000) begin
            @(posedge clk);
            #1;
            k++;
        end
        check_bit(k >= 2000, 1'b1, "power-up pause");
        check_bit(m_ref >= 8, 1'b1, "wake-up refreshes");
        check_int(m_early, 0, "access before wake-up");
    endtask : t_wakeup

    task automatic t_refuse;
        req_lanes = 4'h0;
        req_valid = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check_bit(req_ready, 1'b0, "zero-lane request");
        req_valid = 1'b0;
        req_lanes = 4'hF;
    endtask : t_refuse

    task automatic t_lanes;
        qd_lanes_t m, r;
        qd_addr_t  a;
        for (int i = 0; i < 5; i++) begin
            m = (i == 4) ? 4'hF : qd_lanes_t'(1 << i);
            a = {10'(i * 97 + 1), 10'(1023 - i)};
            access(1'b1, 1'b0, a, 4'hF, 4'hA, r);
            access(1'b1, 1'b0, a, m, 4'h5, r);
            access(1'b0, 1'b0, a, 4'hF, 4'h0, r);
            check_nib(r, (4'hA & ~m) | (4'h5 & m), "lane write");
            access(1'b0, 1'b0, a, m, 4'h0, r);
            check_nib(r, 4'h5 & m, "lane read");
        end
        access(1'b0, 1'b0, {10'd1, 10'd1023}, 4'hF, 4'h0, r);
        check_nib(r, 4'hB, "address halves");
    endtask : t_lanes

    task automatic t_rmw;
        qd_lanes_t r;
        access(1'b1, 1'b0, 20'h3_00C1, 4'hF, 4'h3, r);
        access(1'b0, 1'b1, 20'h3_00C1, 4'hF, 4'hC, r);
        check_nib(r, 4'h3, "read-write old data");
        access(1'b0, 1'b0, 20'h3_00C1, 4'hF, 4'h0, r);
        check_nib(r, 4'hC, "read-write new data");
        access(1'b1, 1'b1, 20'h3_00C1, 4'h6, 4'h9, r);
        check_nib(r, 4'h4, "partial read-write");
        access(1'b0, 1'b0, 20'h3_00C1, 4'hF, 4'h0, r);
        check_nib(r, 4'h8, "partial late write");
    endtask : t_rmw

    task automatic t_refresh;
        int r0;
        r0 = m_ref;
        repeat (1300) @(posedge clk);
        #1;
        check_bit(m_ref - r0 >= 2, 1'b1, "refresh rate low");
        check_bit(m_ref - r0 <= 3, 1'b1, "refresh rate high");
        check_bit(init_done, 1'b1, "no repeated wake-up");
    endtask : t_refresh

    initial begin
        repeat (16) @(posedge clk);
        #1;
        t_reset();
        rst_n = 1'b1;
        t_wakeup();
        t_refuse();
        t_lanes();
        t_rmw();
        t_refresh();
        check_int(clash, 0, "data pin clash");
        complete_run();
    end

    // a whole run needs about 3500 cycles
    initial begin
        #(8000 * 50);
        bad_count++;
        complete_run();
    end
endmodule : qd_ctrl_test
